//--- core/cycle_timer.v
/*
 * Restartable down-counting timer that reports expiry as a level.
 * Assumes the load value fits in 24 bits and is at least one cycle.
 */
`timescale 1ns/1ps

module cycle_timer #(
	parameter [23:0] LOAD = 24'h000001
) (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Control and status
	input wire restart,
	input wire run,
	output wire expired
);

	reg [23:0] count_q;

	// ============================================================
	// Counter
	// ============================================================
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= 24'h000000;
		end else if (restart) begin
			count_q <= LOAD;
		end else if (run && count_q != 24'h000000) begin
			count_q <= count_q - 24'h000001;
		end
	end

	assign expired = (count_q == 24'h000000);

endmodule // cycle_timer

//--- core/pin_sync.v
/*
 * Three-stage synchroniser with agreement filter for one asynchronous comparator input.
 * Assumes the input is a slow level from an analog comparator outside the clock domain.
 */
`timescale 1ns/1ps

module pin_sync (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Pin and filtered level
	input wire pinIn,
	output reg levelOut
);

	reg meta_q;
	reg stage2_q;
	reg stage3_q;

	// ============================================================
	// Stages
	// ============================================================
	// The first stage is read only by the second one; a change is accepted once the
	// second and third stages agree, which rejects a single-cycle glitch.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			stage2_q <= 1'b0;
			stage3_q <= 1'b0;
			levelOut <= 1'b0;
		end else begin
			meta_q <= pinIn;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			if (stage2_q == stage3_q) begin
				levelOut <= stage3_q;
			end
		end
	end

endmodule // pin_sync

//--- core/quasi_resonant_valley_counter.v
/*
 * Digital control of a quasi-resonant flyback controller: start-up hand-off, stepped
 * soft-start of the peak current limit, feedback-driven valley counter, zero-crossing
 * counter, gate drive set/reset and output overvoltage latch-off.
 * Assumes all comparator inputs are asynchronous levels from the analog stage and that
 * the gate gate_drive_output follows gateDrive directly.
 */
// Functional notes
// - Supply above turn-on threshold disables pre-charge and starts soft-started switching.
// - Soft-start is time based, fixed total duration, split into four equal steps.
// - Peak current limit rises one step at a time from initial to final level.
// - Feedback thresholds are evaluated once per 48 ms period; counter updates then.
// - Feedback always below low threshold: valley counter increments, saturating at 7.
// - Feedback above low but never above high threshold: counter holds.
// - Feedback above high but never above reset threshold: counter decrements, floor 1.
// - Feedback above reset threshold forces the valley counter to 1.
// - Valley counter stays in 1..7; out-of-range requests are ignored.
// - Valley counter starts at 1 at start-up.
// - Low and high count thresholds are chosen internally by sensed line level.
// - Zero-crossing counter saturates between 0 and 7.
// - After turn-off each falling valley-sense crossing increments the zero-crossing count.
// - Zero-crossing counter clears whenever gate drive goes high.
// - Valley sense above overvoltage threshold while off latches off after blanking.
// - Turn-on comes from counter logic; turn-off from analog current comparison.
// - After ringing suppression, turn on when zero-crossing count reaches valley count.
// - Gate drive off for maximum off time turns on regardless of counters.
// - Scaled current sense above feedback resets the output flip-flop.
`timescale 1ns/1ps
`include "qr_valley_defs.vh"

module quasi_resonant_valley_counter (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Supply monitor
	input wire supplyAboveTurnOn,
	output reg prechargeEnable,
	// Feedback comparators, both threshold sets
	input wire feedbackAboveUpLowLine,
	input wire feedbackAboveDownLowLine,
	input wire feedbackAboveUpHighLine,
	input wire feedbackAboveDownHighLine,
	input wire feedbackAboveResetThreshold,
	input wire highLineSensed,
	// Valley sense comparators
	input wire valleySenseAboveDetect,
	input wire valleySenseAboveOvervoltage,
	// Current comparator
	input wire currentAboveFeedback,
	// Gate drive and status
	output reg gateDrive,
	output reg [`CS_LIMIT_W-1:0] csLimitStep,
	output reg softStartActive,
	output reg latchedOff,
	output reg [`CNT_W-1:0] valleyCount,
	output reg [`CNT_W-1:0] zeroCrossCount
);

	// ============================================================
	// State encoding
	// ============================================================
	localparam [1:0] ST_PRECHARGE = 2'h0;
	localparam [1:0] ST_SOFTSTART = 2'h1;
	localparam [1:0] ST_RUN = 2'h2;
	localparam [1:0] ST_LATCHED = 2'h3;

	// The cycle counts are integer arithmetic; all fit the 24-bit timers, so the top bits go.
	localparam integer SS_STEP_INT = `SOFTSTART_STEP_CYCLES;
	localparam integer EVAL_INT = `EVAL_PERIOD_CYCLES;
	localparam integer RING_INT = `RING_SUPPRESS_CYCLES;
	localparam integer MAXOFF_INT = `MAX_OFF_CYCLES;
	localparam integer OVP_INT = `OVP_BLANK_CYCLES;
	localparam [23:0] SS_STEP_LOAD = SS_STEP_INT[23:0];
	localparam [23:0] EVAL_LOAD = EVAL_INT[23:0];
	localparam [23:0] RING_LOAD = RING_INT[23:0];
	localparam [23:0] MAXOFF_LOAD = MAXOFF_INT[23:0];
	localparam [23:0] OVP_LOAD = OVP_INT[23:0];

	// ============================================================
	// Input synchronisers
	// ============================================================
	wire [9:0] rawIn;
	wire [9:0] syncIn;

	assign rawIn = {supplyAboveTurnOn, feedbackAboveUpLowLine, feedbackAboveDownLowLine,
		feedbackAboveUpHighLine, feedbackAboveDownHighLine, feedbackAboveResetThreshold,
		highLineSensed, valleySenseAboveDetect, valleySenseAboveOvervoltage,
		currentAboveFeedback};

	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1) begin : g_sync
			pin_sync u_sync (
				.clk(clk),
				.rst_n(rst_n),
				.pinIn(rawIn[gi]),
				.levelOut(syncIn[gi])
			);
		end
	endgenerate

	wire supplyOk = syncIn[9];
	wire fbUpLow = syncIn[8];
	wire fbDownLow = syncIn[7];
	wire fbUpHigh = syncIn[6];
	wire fbDownHigh = syncIn[5];
	wire fbReset = syncIn[4];
	wire lineHigh = syncIn[3];
	wire zcAbove = syncIn[2];
	wire ovpAbove = syncIn[1];
	wire csTrip = syncIn[0];

	// Threshold set follows the sensed line so foldback does not move the count points.
	wire fbAboveUp = lineHigh ? fbUpHigh : fbUpLow;
	wire fbAboveDown = lineHigh ? fbDownHigh : fbDownLow;

	// ============================================================
	// Sequencer
	// ============================================================
	reg [1:0] state_q;
	reg [1:0] state_d;
	wire ssTick;
	wire switching = (state_q == ST_SOFTSTART) || (state_q == ST_RUN);
	wire ovpExpired;
	reg ovpArm_q;

	cycle_timer #(.LOAD(SS_STEP_LOAD)) u_ss_timer (
		.clk(clk),
		.rst_n(rst_n),
		.restart(state_q == ST_PRECHARGE || ssTick),
		.run(state_q == ST_SOFTSTART),
		.expired(ssTick)
	);

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_PRECHARGE: begin
				if (supplyOk) begin
					state_d = ST_SOFTSTART;
				end
			end
			ST_SOFTSTART: begin
				if (ssTick && csLimitStep == `CS_LIMIT_FINAL) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			ST_LATCHED: begin
				state_d = ST_LATCHED;
			end
			default: begin
				state_d = ST_PRECHARGE;
			end
		endcase
		if (switching && ovpArm_q && ovpExpired && ovpAbove && !gateDrive) begin
			state_d = ST_LATCHED;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_PRECHARGE;
			csLimitStep <= `CS_LIMIT_INIT;
			prechargeEnable <= 1'b1;
			softStartActive <= 1'b0;
			latchedOff <= 1'b0;
		end else begin
			state_q <= state_d;
			prechargeEnable <= (state_d == ST_PRECHARGE);
			softStartActive <= (state_d == ST_SOFTSTART);
			latchedOff <= (state_d == ST_LATCHED);
			// Four equal steps: the limit moves once per step interval up to final.
			if (state_q == ST_SOFTSTART && ssTick && csLimitStep != `CS_LIMIT_FINAL) begin
				csLimitStep <= csLimitStep + 2'h1;
			end
		end
	end

	// ============================================================
	// Feedback evaluation and valley counter
	// ============================================================
	wire evalTick;
	reg seenAboveUp_q;
	reg seenAboveDown_q;
	reg seenAboveReset_q;

	cycle_timer #(.LOAD(EVAL_LOAD)) u_eval_timer (
		.clk(clk),
		.rst_n(rst_n),
		.restart(!switching || evalTick),
		.run(switching),
		.expired(evalTick)
	);

	// Saturating step: a request that would leave the range leaves the value unchanged.
	function [`CNT_W-1:0] satStep;
		input [`CNT_W-1:0] value;
		input up;
		input [`CNT_W-1:0] lo;
		input [`CNT_W-1:0] hi;
		begin
			if (up) begin
				satStep = (value >= hi) ? hi : value + 3'h1;
			end else begin
				satStep = (value <= lo) ? lo : value - 3'h1;
			end
		end
	endfunction

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			valleyCount <= `VALLEY_MIN;
			seenAboveUp_q <= 1'b0;
			seenAboveDown_q <= 1'b0;
			seenAboveReset_q <= 1'b0;
		end else if (!switching) begin
			valleyCount <= `VALLEY_MIN;
			seenAboveUp_q <= 1'b0;
			seenAboveDown_q <= 1'b0;
			seenAboveReset_q <= 1'b0;
		end else if (evalTick) begin
			if (seenAboveReset_q || fbReset) begin
				valleyCount <= `VALLEY_MIN;
			end else if (seenAboveDown_q || fbAboveDown) begin
				valleyCount <= satStep(valleyCount, 1'b0, `VALLEY_MIN, `VALLEY_MAX);
			end else if (!(seenAboveUp_q || fbAboveUp)) begin
				valleyCount <= satStep(valleyCount, 1'b1, `VALLEY_MIN, `VALLEY_MAX);
			end else begin
				// The low threshold was crossed but not the high one.
				valleyCount <= valleyCount;
			end
			seenAboveUp_q <= 1'b0;
			seenAboveDown_q <= 1'b0;
			seenAboveReset_q <= 1'b0;
		end else begin
			seenAboveUp_q <= seenAboveUp_q | fbAboveUp;
			seenAboveDown_q <= seenAboveDown_q | fbAboveDown;
			seenAboveReset_q <= seenAboveReset_q | fbReset;
		end
	end

	// ============================================================
	// Zero-crossing counter
	// ============================================================
	reg zcPrev_q;
	wire zcFall = zcPrev_q && !zcAbove;
	wire gateRise;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zcPrev_q <= 1'b0;
			zeroCrossCount <= `ZC_MIN;
		end else begin
			zcPrev_q <= zcAbove;
			if (gateRise) begin
				zeroCrossCount <= `ZC_MIN;
			end else if (!gateDrive && zcFall) begin
				zeroCrossCount <= satStep(zeroCrossCount, 1'b1, `ZC_MIN, `ZC_MAX);
			end
		end
	end

	// ============================================================
	// Gate drive
	// ============================================================
	wire ringDone;
	wire maxOffDone;

	cycle_timer #(.LOAD(RING_LOAD)) u_ring_timer (
		.clk(clk),
		.rst_n(rst_n),
		.restart(gateDrive),
		.run(1'b1),
		.expired(ringDone)
	);

	cycle_timer #(.LOAD(MAXOFF_LOAD)) u_maxoff_timer (
		.clk(clk),
		.rst_n(rst_n),
		.restart(gateDrive),
		.run(1'b1),
		.expired(maxOffDone)
	);

	// Blanking restarts while the switch is on or the overvoltage level is low, so brief ringing cannot latch the part.
	cycle_timer #(.LOAD(OVP_LOAD)) u_ovp_timer (
		.clk(clk),
		.rst_n(rst_n),
		.restart(gateDrive || !ovpAbove),
		.run(1'b1),
		.expired(ovpExpired)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovpArm_q <= 1'b0;
		end else begin
			ovpArm_q <= !gateDrive && ovpAbove;
		end
	end

	// Turn-on is counter and timer driven; turn-off follows the comparator, or latch-off and leaving the switching states.
	wire turnOn = switching && state_d != ST_LATCHED && !gateDrive && !csTrip &&
		((ringDone && zeroCrossCount >= valleyCount) || maxOffDone);
	assign gateRise = turnOn;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gateDrive <= 1'b0;
		end else if (!switching || state_d == ST_LATCHED) begin
			gateDrive <= 1'b0;
		end else if (gateDrive && csTrip) begin
			gateDrive <= 1'b0;
		end else if (turnOn) begin
			gateDrive <= 1'b1;
		end
	end

endmodule // quasi_resonant_valley_counter

//--- shared/qr_valley_defs.vh
/*
 * Timing constants, counter limits and soft-start levels for the quasi-resonant valley counter.
 * Assumes a 20 MHz system clock; each time is kept in its own unit and turned into cycles here.
 */
`ifndef QR_VALLEY_DEFS_VH
`define QR_VALLEY_DEFS_VH

// ============================================================
// Clock
// ============================================================
`define CLK_FREQ_HZ 20000000

// ============================================================
// Soft-start
// ============================================================
`define SOFTSTART_DURATION_MS 12
`define SOFTSTART_STEPS 4
`define SOFTSTART_STEP_CYCLES ((`SOFTSTART_DURATION_MS * (`CLK_FREQ_HZ / 1000)) / `SOFTSTART_STEPS)
`define CS_LIMIT_W 2
`define CS_LIMIT_INIT 2'h0
`define CS_LIMIT_FINAL 2'h3

// ============================================================
// Feedback evaluation period
// ============================================================
`define EVAL_PERIOD_MS 48
`define EVAL_PERIOD_CYCLES (`EVAL_PERIOD_MS * (`CLK_FREQ_HZ / 1000))

// ============================================================
// Counters
// ============================================================
`define CNT_W 3
`define VALLEY_MIN 3'h1
`define VALLEY_MAX 3'h7
`define ZC_MIN 3'h0
`define ZC_MAX 3'h7

// ============================================================
// Gate timing
// ============================================================
`define RING_SUPPRESS_US 2
`define RING_SUPPRESS_CYCLES (`RING_SUPPRESS_US * (`CLK_FREQ_HZ / 1000000))
`define MAX_OFF_US 50
`define MAX_OFF_CYCLES (`MAX_OFF_US * (`CLK_FREQ_HZ / 1000000))
`define OVP_BLANK_US 5
`define OVP_BLANK_CYCLES (`OVP_BLANK_US * (`CLK_FREQ_HZ / 1000000))

`endif

//--- verification/qr_stage_model.sv
/* Behavioural flyback stage: current comparator, valley ringing, feedback and overvoltage levels.
   Assumes the bench changes its controls only between switching cycles. */
`timescale 1ns/1ps
module qr_stage_model (
	// Clock and gate
	input wire logic clk,
	input wire logic gateDrive,
	// Bench controls
	input wire logic [7:0] onCycles,
	input wire logic [3:0] rings,
	input wire logic [1:0] fbLevel,
	input wire logic ovpReq,
	// Comparator levels
	output logic currentAboveFeedback,
	output logic valleySenseAboveDetect,
	output logic valleySenseAboveOvervoltage,
	output logic fbUp,
	output logic fbDown,
	output logic fbReset
);
	// ========
	// Stage
	// ========
	int onCnt;
	int offCnt;
	initial begin
		onCnt = 0;
		offCnt = 0;
		currentAboveFeedback = 1'b0;
		valleySenseAboveDetect = 1'b0;
		valleySenseAboveOvervoltage = 1'b0;
	end
	always @(negedge clk) begin
		onCnt <= gateDrive ? onCnt + 1 : 0;
		offCnt <= gateDrive ? 0 : offCnt + 1;
		currentAboveFeedback <= gateDrive && onCnt >= onCycles;
		// Ringing with a 20-cycle period; once damped the sense level sits low, as when clamped.
		valleySenseAboveDetect <= !gateDrive && offCnt < rings * 20 && (offCnt % 20) < 10;
		valleySenseAboveOvervoltage <= ovpReq && !gateDrive;
	end
	assign fbUp = fbLevel >= 2'h1;
	assign fbDown = fbLevel >= 2'h2;
	assign fbReset = fbLevel == 2'h3;
endmodule // qr_stage_model

//--- verification/quasi_resonant_valley_counter_checker.sv
/* Concurrent checks on the valley counter block's ports.
   Assumes a single clock domain and a bind from the bench. */
`timescale 1ns/1ps
module quasi_resonant_valley_counter_checker (
	// Clock and reset
	input wire clk,
	input wire rst_n,
	// Observed ports
	input wire prechargeEnable,
	input wire softStartActive,
	input wire [1:0] csLimitStep,
	input wire [2:0] valleyCount,
	input wire [2:0] zeroCrossCount,
	input wire gateDrive,
	input wire currentAboveFeedback,
	input wire valleySenseAboveOvervoltage,
	input wire latchedOff
);
	// ========
	// Helpers
	// ========
	logic [10:0] offCnt;
	logic [16:0] stepCnt;
	logic [1:0] prevStep;
	logic seenOn;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			offCnt <= 11'h000;
			stepCnt <= 17'h00000;
			prevStep <= 2'h0;
			seenOn <= 1'b0;
		end else begin
			offCnt <= (gateDrive || offCnt == 11'h7FF) ? 11'h000 : offCnt + 11'h001;
			stepCnt <= (prechargeEnable || csLimitStep != prevStep) ? 17'h00001 : stepCnt + 17'h00001;
			prevStep <= csLimitStep;
			seenOn <= seenOn | gateDrive;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ========
	// Checks
	// ========
	a_precharge_handoff: assert property ($fell(prechargeEnable) |-> softStartActive)
		else $error("pre-charge dropped without soft-start");
	a_step_spacing: assert property (csLimitStep != prevStep |->
		stepCnt >= 17'h0EA5B && stepCnt <= 17'h0EA65)
		else $error("soft-start step spacing wrong");
	a_step_by_one: assert property (!$stable(csLimitStep) |->
		csLimitStep == $past(csLimitStep) + 2'h1)
		else $error("limit step skipped");
	a_valley_range: assert property (valleyCount >= 3'h1)
		else $error("valley count below range");
	a_valley_start: assert property (prechargeEnable |-> valleyCount == 3'h1)
		else $error("valley count not one at start-up");
	a_valley_move: assert property (!$stable(valleyCount) |-> valleyCount == 3'h1 ||
		valleyCount == $past(valleyCount) + 3'h1 || valleyCount == $past(valleyCount) - 3'h1)
		else $error("valley count jumped");
	a_zc_clear: assert property ($rose(gateDrive) |-> zeroCrossCount == 3'h0)
		else $error("zero-crossing count not cleared");
	a_zc_count: assert property (!$stable(zeroCrossCount) && zeroCrossCount != 3'h0 |->
		!gateDrive && zeroCrossCount == $past(zeroCrossCount) + 3'h1)
		else $error("zero-crossing count moved wrongly");
	a_turn_off: assert property ($rose(currentAboveFeedback) && gateDrive |-> ##[1:8] !gateDrive)
		else $error("gate not turned off by current");
	a_off_window: assert property ($rose(gateDrive) && seenOn |->
		offCnt >= 11'h026 && offCnt <= 11'h3EB)
		else $error("off time outside window");
	a_latch_hold: assert property (latchedOff |=> latchedOff && !gateDrive)
		else $error("latch-off released");
	a_ovp_blank: assert property ($rose(latchedOff) |-> $past(valleySenseAboveOvervoltage, 90))
		else $error("latch-off without blanking");
endmodule // quasi_resonant_valley_counter_checker

//--- verification/quasi_resonant_valley_counter_test.sv
/* Self-checking bench for the valley counter block with a behavioural power stage.
   Assumes the fixed 20 MHz timing constants of the block. */
`timescale 1ns/1ps
module quasi_resonant_valley_counter_test;
	// ========
	// Signals
	// ========
	logic clk, rst_n, supplyAboveTurnOn, highLineSensed, ovpReq;
	logic [7:0] onCycles;
	logic [3:0] rings;
	logic [1:0] fbLevel;
	wire curAbove, senseDetect, senseOvp, fbUp, fbDown, fbReset;
	wire prechargeEnable, gateDrive, softStartActive, latchedOff;
	wire [1:0] csLimitStep;
	wire [2:0] valleyCount, zeroCrossCount;
	int errors, cmp_count, cyc, t0, n;
	logic [2:0] zc;

	quasi_resonant_valley_counter dut_u (.clk(clk), .rst_n(rst_n),
		.supplyAboveTurnOn(supplyAboveTurnOn), .prechargeEnable(prechargeEnable),
		.feedbackAboveUpLowLine(fbUp), .feedbackAboveDownLowLine(fbDown),
		.feedbackAboveUpHighLine(fbUp), .feedbackAboveDownHighLine(fbDown),
		.feedbackAboveResetThreshold(fbReset), .highLineSensed(highLineSensed),
		.valleySenseAboveDetect(senseDetect), .valleySenseAboveOvervoltage(senseOvp),
		.currentAboveFeedback(curAbove), .gateDrive(gateDrive), .csLimitStep(csLimitStep),
		.softStartActive(softStartActive), .latchedOff(latchedOff),
		.valleyCount(valleyCount), .zeroCrossCount(zeroCrossCount));
	qr_stage_model stage_u (.clk(clk), .gateDrive(gateDrive), .onCycles(onCycles),
		.rings(rings), .fbLevel(fbLevel), .ovpReq(ovpReq), .currentAboveFeedback(curAbove),
		.valleySenseAboveDetect(senseDetect), .valleySenseAboveOvervoltage(senseOvp),
		.fbUp(fbUp), .fbDown(fbDown), .fbReset(fbReset));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) cyc++;

	// ========
	// Tasks
	// ========
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Counts falling edges until the gate reaches the level, sampling the count on the way.
	task wait_gate(input logic lvl, input int limit);
		n = 0;
		while (gateDrive !== lvl && n < limit) begin
			zc = zeroCrossCount;
			@(negedge clk);
			n++;
		end
	endtask
	task t_reset;
		check({prechargeEnable, gateDrive, softStartActive, latchedOff}, 4'h8);
		check({csLimitStep, valleyCount, zeroCrossCount}, 8'h08);
	endtask
	task t_startup;
		supplyAboveTurnOn = 1'b1;
		t0 = cyc;
		n = 0;
		while (prechargeEnable !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		check(n >= 4 && n <= 8, 1);
		check({softStartActive, csLimitStep, valleyCount}, 6'h21);
	endtask
	task t_valley_on;
		rings = 4'h3;
		// The first pulse after start-up may still be pending; measure a whole off time.
		wait_gate(1'b1, 3000);
		wait_gate(1'b0, 3000);
		wait_gate(1'b1, 3000);
		check(n >= 40 && n <= 50, 1);
		check(zc, 3'h2);
		check(zeroCrossCount, 3'h0);
		wait_gate(1'b0, 3000);
		check(n >= 31 && n <= 40, 1);
	endtask
	task t_max_off;
		// Non-blocking, so the stage model samples the new value one falling edge later.
		rings <= 4'h0;
		wait_gate(1'b1, 3000);
		wait_gate(1'b0, 3000);
		wait_gate(1'b1, 3000);
		check(n >= 995 && n <= 1005, 1);
		check(zc, 3'h0);
	endtask
	task t_softstart;
		fbLevel = 2'h3;
		highLineSensed = 1'b1;
		while (csLimitStep === 2'h0 && cyc - t0 < 70000) @(negedge clk);
		check(cyc - t0 >= 60000 && cyc - t0 <= 60015, 1);
		check({softStartActive, csLimitStep}, 3'h5);
	endtask
	task t_ovp;
		wait_gate(1'b1, 3000);
		wait_gate(1'b0, 3000);
		ovpReq <= 1'b1;
		repeat (50) @(negedge clk);
		ovpReq <= 1'b0;
		repeat (10) @(negedge clk);
		check(latchedOff, 1'b0);
		wait_gate(1'b1, 3000);
		wait_gate(1'b0, 3000);
		ovpReq <= 1'b1;
		n = 0;
		while (latchedOff !== 1'b1 && n < 150) begin
			@(negedge clk);
			n++;
		end
		check(n >= 100 && n <= 110, 1);
		ovpReq <= 1'b0;
		n = 0;
		repeat (2000) begin
			@(negedge clk);
			n += gateDrive;
		end
		check({n[3:0], latchedOff}, 5'h01);
	endtask

	// ========
	// Sequence
	// ========
	initial begin
		errors = 0;
		cmp_count = 0;
		cyc = 0;
		rst_n = 1'b0;
		supplyAboveTurnOn = 1'b0;
		highLineSensed = 1'b0;
		ovpReq = 1'b0;
		onCycles = 8'h1E;
		rings = 4'h3;
		fbLevel = 2'h1;
		repeat (2) @(negedge clk);
		t_reset();
		rst_n = 1'b1;
		@(negedge clk);
		t_startup();
		t_valley_on();
		t_max_off();
		t_softstart();
		t_ovp();
		print_verdict();
	end
	initial begin
		#(80000 * 50);
		errors++;
		print_verdict();
	end
endmodule // quasi_resonant_valley_counter_test

bind quasi_resonant_valley_counter quasi_resonant_valley_counter_checker chk_u (.clk(clk),
	.rst_n(rst_n), .prechargeEnable(prechargeEnable), .softStartActive(softStartActive),
	.csLimitStep(csLimitStep), .valleyCount(valleyCount), .zeroCrossCount(zeroCrossCount),
	.gateDrive(gateDrive), .currentAboveFeedback(currentAboveFeedback),
	.valleySenseAboveOvervoltage(valleySenseAboveOvervoltage), .latchedOff(latchedOff));
